// ===== design/mscp_regs.svh
// Field positions, reset values and timing constants for the motor serial configuration port.
`ifndef MSCP_REGS_SVH
`define MSCP_REGS_SVH

`define MSCP_WORD_W        14
`define MSCP_LONG_BITS     21
`define MSCP_SHORT_BITS    16
`define MSCP_ID_HI         20
`define MSCP_ID_LO         18
`define MSCP_LSEL_HI       17
`define MSCP_LSEL_LO       14
`define MSCP_SSEL_HI       15
`define MSCP_SSEL_LO       14
`define MSCP_ID_ALL        3'h0

`define MSCP_LSEL_WDOG     4'hF
`define MSCP_LSEL_CHOP_A   4'h0
`define MSCP_LSEL_CHOP_B   4'h1
`define MSCP_LSEL_COMMON   4'h2
`define MSCP_LSEL_TEST     4'h3
`define MSCP_LSEL_PER_A    4'h4
`define MSCP_LSEL_PER_B    4'h5
`define MSCP_LSEL_ON_A     4'h6
`define MSCP_LSEL_ON_B     4'h7
`define MSCP_SSEL_CHOP_A   2'h0
`define MSCP_SSEL_CHOP_B   2'h1
`define MSCP_SSEL_COMMON   2'h2

`define MSCP_CHOP_RESET    14'h0040
`define MSCP_ZERO_WORD     14'h0000
`define MSCP_OFF_RESET     5'h10
`define MSCP_OFF_TK_RESET  10'h087
`define MSCP_FD_TK_RESET   10'h007

`define MSCP_BLANK_HI      1
`define MSCP_BLANK_LO      0
`define MSCP_OFF_HI        6
`define MSCP_OFF_LO        2
`define MSCP_FD_HI         10
`define MSCP_FD_LO         7
`define MSCP_ZC_BIT        11
`define MSCP_SR_BIT        12
`define MSCP_INT_DECAY_BIT 7
`define MSCP_EXT_DECAY_BIT 8
`define MSCP_DIR_BIT       9
`define MSCP_DAC_HI        13
`define MSCP_DAC_LO        10
`define MSCP_CNT_HI        12
`define MSCP_ON_DIR_BIT    13
`define MSCP_WDOG_HI       1

`define MSCP_OSC_HZ        40000000
`define MSCP_REF_HZ        25000000
`define MSCP_WAKE_NS       10000
`define MSCP_WAKE_CYC      ((`MSCP_WAKE_NS * (`MSCP_REF_HZ / 1000000) + 999) / 1000)
`define MSCP_WD1_S         60
`define MSCP_WD2_S         180
`define MSCP_WD3_S         300

`endif

// ===== design/mscp_pkg.sv
// Types shared by the motor serial configuration port.
package mscp_pkg;

   typedef enum logic [1:0] {MSCP_FMT_LONG, MSCP_FMT_SHORT} mscp_fmt_t;

   typedef logic [13:0] mscp_word_t;

endpackage : mscp_pkg

// ===== design/mscp_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
`timescale 1ns/1ps
module mscp_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   // Data
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } mscp_sync_state_t;

   mscp_sync_state_t s_reg;
   mscp_sync_state_t s_next;

   always_comb
   begin
      s_next      = s_reg;
      s_next.meta = d_i;
      s_next.sync = s_reg.meta;
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign q_o = s_reg.sync;
endmodule : mscp_sync

// ===== design/mscp_wdog.sv
// Watchdog timer that turns the motor output off after the programmed time.
`timescale 1ns/1ps
`include "mscp_regs.svh"
module mscp_wdog
   import mscp_pkg::*;
#(
   parameter longint unsigned TICKS_PER_S = `MSCP_REF_HZ
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Control
   input  wire logic [1:0] code_i,
   input  wire logic       restart_i,
   output logic            expired_o
);
   typedef struct packed {
      logic [39:0] count;
      logic        expired;
   } mscp_wdog_state_t;

   mscp_wdog_state_t s_reg;
   mscp_wdog_state_t s_next;
   logic [39:0]      limit;

   function automatic logic [39:0] wd_limit(input logic [1:0] code);
      case (code)
         2'h1:    wd_limit = 40'(`MSCP_WD1_S * TICKS_PER_S);
         2'h2:    wd_limit = 40'(`MSCP_WD2_S * TICKS_PER_S);
         2'h3:    wd_limit = 40'(`MSCP_WD3_S * TICKS_PER_S);
         default: wd_limit = '0;
      endcase
   endfunction : wd_limit

   always_comb
   begin
      limit  = wd_limit(code_i);
      s_next = s_reg;
      if (restart_i)
      begin
         s_next.count   = '0;
         s_next.expired = 1'b0;
      end
      else if (limit != '0 && !s_reg.expired)
      begin
         if (s_reg.count >= limit - 40'h1)
            s_next.expired = 1'b1;
         else
            s_next.count = s_reg.count + 40'h1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign expired_o = s_reg.expired;
endmodule : mscp_wdog

// ===== design/mscp_port.sv
// Serial configuration port of the H-bridge driver: link shifter, word store and decoded settings.
// Notes on behaviour
// - long frame is 21 bits, MSB first
// - bits 20..18 carry the device ID
// - odd ID devices sample on falling clock
// - ID 000 and even IDs sample rising
// - shift while strobe low, store on rise
// - long word select decodes nine words; port keeps watchdog, chop A, common, period A, on A
// - ignore serial input 10 us after wake
// - short frame is 16 bits, rising edge
// - short select picks chop, B or common; port keeps chop A and common only
// - chop word fields, off time resets 10000
// - common word decay, direction, DAC fields
// - period A holds 13-bit count
// - on-time A holds count and direction
// - times counted from 40 MHz oscillator
// - off time is (1+N)*8 oscillator ticks minus one
// - fast decay time uses same formula
// - blank time masks comparator after events
// - zero-current bit selects rectifier stop point
// - DAC code scales trip, zero disables
// - bit 12 enables synchronous rectification
// - active mode with sleep high
// - sleep low holds port in reset
// - direction from last written common or on-time A word
// - watchdog codes, expiry off, rewrite restarts
// - period zero selects external enable
`timescale 1ns/1ps
`include "mscp_regs.svh"
module mscp_port
   import mscp_pkg::*;
#(
   parameter int WAKE_CYCLES = `MSCP_WAKE_CYC,
   parameter longint unsigned TICKS_PER_S = `MSCP_REF_HZ
) (
   // Core clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        reset_n_i,
   // Serial link, clocked by the host
   input  wire logic        ser_clk_i,
   input  wire logic        ser_data_i,
   input  wire logic        load_strobe_i,
   // Straps and mode pins
   input  wire logic        device_select_pin_0_i,
   input  wire logic        device_select_pin_1_i,
   input  wire logic        device_select_pin_2_i,
   input  wire logic        short_format_i,
   input  wire logic        sleep_n_i,
   // Decoded settings and status
   output mscp_word_t       chop_word_o,
   output mscp_word_t       common_word_o,
   output mscp_word_t       period_word_o,
   output mscp_word_t       on_word_o,
   output logic [1:0]       blank_sel_o,
   output logic [4:0]       off_time_o,
   output logic [3:0]       fast_decay_o,
   output logic             zero_current_mode_o,
   output logic             sync_rect_en_o,
   output logic             int_decay_slow_o,
   output logic             ext_decay_slow_o,
   output logic             direction_o,
   output logic [3:0]       dac_code_o,
   output logic             current_limit_en_o,
   output logic             ext_enable_mode_o,
   output logic [9:0]       off_ticks_o,
   output logic [9:0]       fast_decay_ticks_o,
   output logic             bridge_active_o,
   output logic             motor_off_o,
   output logic             frame_done_o
);
   ////////////////////////////////////////////////////////////////////////////
   // Reset release and pin synchronisation.

   logic       rst_n_q1;
   logic       rst_n;
   logic [5:0] pins_sync;
   logic       sleep_s;
   logic [2:0] pin_id;
   logic       short_s;
   logic       port_rst_n;

   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rst_n_q1 <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_n_q1 <= 1'b1;
         rst_n    <= rst_n_q1;
      end
   end

   mscp_sync #(.W(6)) u_pin_sync (
      .clk_i   (ref_clk_i),
      .rst_n_i (rst_n),
      .d_i     ({sleep_n_i, short_format_i, device_select_pin_2_i,
                 device_select_pin_1_i, device_select_pin_0_i, load_strobe_i}),
      .q_o     (pins_sync)
   );
   assign sleep_s = pins_sync[5];
   assign short_s = pins_sync[4];
   assign pin_id  = pins_sync[3:1];

   ////////////////////////////////////////////////////////////////////////////
   // Link domain: shifters on both clock edges, gated by the strobe.
   // The strobe rise is a frame's last event, so the captured frame is taken
   // over by the core domain through a toggle and stays stable until the next.

   logic        link_rst_n;
   logic [20:0] shift_rise_reg;
   logic [20:0] shift_fall_reg;
   logic [20:0] frame_reg;
   logic        frame_tgl_reg;

   assign port_rst_n = rst_n & sleep_s;
   assign link_rst_n = port_rst_n;

   // The wake hold-off is judged in the core at the strobe fall: the host clock stops between
   // frames, so a synchroniser clocked by it would swallow the first bits of the next frame.

   // short frame shifts on rising edges
   always_ff @(posedge ser_clk_i or negedge link_rst_n)
   begin
      if (!link_rst_n)
         shift_rise_reg <= '0;
      else if (!load_strobe_i)
         // first bit ends up at the top
         shift_rise_reg <= {shift_rise_reg[19:0], ser_data_i};
   end

   always_ff @(negedge ser_clk_i or negedge link_rst_n)
   begin
      if (!link_rst_n)
         shift_fall_reg <= '0;
      else if (!load_strobe_i)
         shift_fall_reg <= {shift_fall_reg[19:0], ser_data_i};
   end

   always_ff @(posedge load_strobe_i or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         frame_reg     <= '0;
         frame_tgl_reg <= 1'b0;
      end
      else
      begin
         // odd IDs matching the pins take the falling-edge copy of a long frame
         if (!short_s && shift_fall_reg[`MSCP_ID_LO] && shift_fall_reg[`MSCP_ID_HI:`MSCP_ID_LO] == pin_id)
            frame_reg <= shift_fall_reg;
         else
            frame_reg <= shift_rise_reg;
         frame_tgl_reg <= ~frame_tgl_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Core domain state.

   typedef struct packed {
      logic [12:0] wake_cnt;
      logic        link_en;
      logic        strobe_q;
      logic        armed;
      logic [2:0]  tgl_sync;
      mscp_word_t  wdog;
      mscp_word_t  chop;
      mscp_word_t  common;
      mscp_word_t  period;
      mscp_word_t  on_a;
      logic        dir;
      logic        wd_restart;
      logic        done;
   } mscp_state_t;

   mscp_state_t s_reg;
   mscp_state_t s_next;
   logic [20:0] frame_core;
   logic        frame_evt;
   logic [2:0]  fid;
   logic [3:0]  lsel;
   logic [1:0]  ssel;
   logic        id_ok;
   logic        wd_expired;

   assign frame_core = frame_reg;
   assign frame_evt  = s_reg.tgl_sync[2] ^ s_reg.tgl_sync[1];

   // Ticks of the 40 MHz oscillator: (1+N)*8 - 1.
   function automatic logic [9:0] osc_ticks(input logic [4:0] n);
      osc_ticks = 10'(({5'h0, n} + 10'h1) * 10'h8 - 10'h1);
   endfunction : osc_ticks

   always_comb
   begin
      s_next            = s_reg;
      s_next.wd_restart = 1'b0;
      s_next.done       = 1'b0;
      fid               = frame_core[`MSCP_ID_HI:`MSCP_ID_LO];
      lsel              = frame_core[`MSCP_LSEL_HI:`MSCP_LSEL_LO];
      ssel              = frame_core[`MSCP_SSEL_HI:`MSCP_SSEL_LO];
      id_ok             = (fid == `MSCP_ID_ALL) || (fid == pin_id);
      s_next.tgl_sync   = {s_reg.tgl_sync[1:0], frame_tgl_reg};
      s_next.strobe_q   = pins_sync[0];
      if (s_reg.strobe_q && !pins_sync[0])
         s_next.armed = s_reg.link_en;

      if (s_reg.wake_cnt != 13'(WAKE_CYCLES))
         s_next.wake_cnt = s_reg.wake_cnt + 13'h1;
      else
         s_next.link_en = 1'b1;

      if (frame_evt && s_reg.link_en && s_reg.armed)
      begin
         s_next.done = 1'b1;
         if (short_s)
         begin
            if (ssel == `MSCP_SSEL_CHOP_A)
               s_next.chop = frame_core[`MSCP_WORD_W-1:0];
            else if (ssel == `MSCP_SSEL_COMMON)
            begin
               s_next.common = frame_core[`MSCP_WORD_W-1:0];
               s_next.dir    = frame_core[`MSCP_DIR_BIT];
            end
         end
         else if (id_ok)
         begin
            if (lsel == `MSCP_LSEL_WDOG)
            begin
               s_next.wdog       = frame_core[`MSCP_WORD_W-1:0];
               s_next.wd_restart = 1'b1;
            end
            else if (lsel == `MSCP_LSEL_CHOP_A)
               s_next.chop = frame_core[`MSCP_WORD_W-1:0];
            else if (lsel == `MSCP_LSEL_COMMON)
            begin
               s_next.common = frame_core[`MSCP_WORD_W-1:0];
               s_next.dir    = frame_core[`MSCP_DIR_BIT];
            end
            else if (lsel == `MSCP_LSEL_PER_A)
               s_next.period = frame_core[`MSCP_WORD_W-1:0];
            else if (lsel == `MSCP_LSEL_ON_A)
            begin
               s_next.on_a = frame_core[`MSCP_WORD_W-1:0];
               s_next.dir  = frame_core[`MSCP_ON_DIR_BIT];
            end
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge port_rst_n)
   begin
      if (!port_rst_n)
      begin
         s_reg      <= '0;
         s_reg.chop <= `MSCP_CHOP_RESET;
      end
      else
         s_reg <= s_next;
   end

   mscp_wdog #(.TICKS_PER_S(TICKS_PER_S)) u_wdog (
      .clk_i     (ref_clk_i),
      .rst_n_i   (port_rst_n),
      .code_i    (s_reg.wdog[`MSCP_WDOG_HI:0]),
      .restart_i (s_reg.wd_restart),
      .expired_o (wd_expired)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs.

   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         chop_word_o         <= `MSCP_CHOP_RESET;
         common_word_o       <= `MSCP_ZERO_WORD;
         period_word_o       <= `MSCP_ZERO_WORD;
         on_word_o           <= `MSCP_ZERO_WORD;
         blank_sel_o         <= '0;
         off_time_o          <= `MSCP_OFF_RESET;
         fast_decay_o        <= '0;
         zero_current_mode_o <= 1'b0;
         sync_rect_en_o      <= 1'b0;
         int_decay_slow_o    <= 1'b0;
         ext_decay_slow_o    <= 1'b0;
         direction_o         <= 1'b0;
         dac_code_o          <= '0;
         current_limit_en_o  <= 1'b0;
         ext_enable_mode_o   <= 1'b1;
         off_ticks_o         <= `MSCP_OFF_TK_RESET;
         fast_decay_ticks_o  <= `MSCP_FD_TK_RESET;
         bridge_active_o     <= 1'b0;
         motor_off_o         <= 1'b1;
         frame_done_o        <= 1'b0;
      end
      else
      begin
         chop_word_o         <= s_reg.chop;
         common_word_o       <= s_reg.common;
         period_word_o       <= s_reg.period;
         on_word_o           <= s_reg.on_a;
         blank_sel_o         <= s_reg.chop[`MSCP_BLANK_HI:`MSCP_BLANK_LO];
         off_time_o          <= s_reg.chop[`MSCP_OFF_HI:`MSCP_OFF_LO];
         fast_decay_o        <= s_reg.chop[`MSCP_FD_HI:`MSCP_FD_LO];
         zero_current_mode_o <= s_reg.chop[`MSCP_ZC_BIT];
         sync_rect_en_o      <= s_reg.chop[`MSCP_SR_BIT];
         int_decay_slow_o    <= s_reg.common[`MSCP_INT_DECAY_BIT];
         ext_decay_slow_o    <= s_reg.common[`MSCP_EXT_DECAY_BIT];
         direction_o         <= s_reg.dir;
         dac_code_o          <= s_reg.common[`MSCP_DAC_HI:`MSCP_DAC_LO];
         current_limit_en_o  <= s_reg.common[`MSCP_DAC_HI:`MSCP_DAC_LO] != 4'h0;
         ext_enable_mode_o   <= s_reg.period[`MSCP_CNT_HI:0] == 13'h0000;
         off_ticks_o         <= osc_ticks(s_reg.chop[`MSCP_OFF_HI:`MSCP_OFF_LO]);
         fast_decay_ticks_o  <= osc_ticks({1'b0, s_reg.chop[`MSCP_FD_HI:`MSCP_FD_LO]});
         bridge_active_o     <= sleep_s;
         motor_off_o         <= wd_expired | ~sleep_s;
         frame_done_o        <= s_reg.done;
      end
   end
endmodule : mscp_port

// ===== tb/mscp_port_monitor.sv
// Concurrent checks on the ports of the motor serial configuration port.
`timescale 1ns/1ps
module mscp_port_monitor
   import mscp_pkg::*;
#(
   parameter int              WAKE_CYCLES = 250,
   parameter longint unsigned TICKS_PER_S = 25000000
) (
   // Clock, reset and mode
   input wire logic       ref_clk_i,
   input wire logic       reset_n_i,
   input wire logic       sleep_n_i,
   // Stored words
   input wire mscp_word_t chop_word_o,
   input wire mscp_word_t common_word_o,
   input wire mscp_word_t period_word_o,
   input wire mscp_word_t on_word_o,
   // Decoded fields
   input wire logic [1:0] blank_sel_o,
   input wire logic [4:0] off_time_o,
   input wire logic [3:0] fast_decay_o,
   input wire logic       zero_current_mode_o,
   input wire logic       sync_rect_en_o,
   input wire logic       int_decay_slow_o,
   input wire logic       ext_decay_slow_o,
   input wire logic [3:0] dac_code_o,
   input wire logic       current_limit_en_o,
   input wire logic       ext_enable_mode_o,
   input wire logic [9:0] off_ticks_o,
   input wire logic [9:0] fast_decay_ticks_o,
   // Status
   input wire logic       bridge_active_o,
   input wire logic       motor_off_o,
   input wire logic       frame_done_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_asleep; !sleep_n_i [*4]; endsequence
   sequence s_awake; sleep_n_i [*8]; endsequence
   property p_chop_fields;
      $stable(chop_word_o) |-> {sync_rect_en_o, zero_current_mode_o, fast_decay_o, off_time_o, blank_sel_o}
         == chop_word_o[12:0];
   endproperty
   a_chop_fields: assert property (p_chop_fields) else $error("chop fields differ from word");
   property p_common_fields;
      $stable(common_word_o) |-> dac_code_o == common_word_o[13:10]
         && current_limit_en_o == (common_word_o[13:10] != 4'h0)
         && {ext_decay_slow_o, int_decay_slow_o} == common_word_o[8:7];
   endproperty
   a_common_fields: assert property (p_common_fields) else $error("common fields differ");
   property p_off_ticks;
      $stable(off_time_o) |-> off_ticks_o == 10'(({5'h00, off_time_o} + 10'h001) * 10'h008 - 10'h001);
   endproperty
   a_off_ticks: assert property (p_off_ticks) else $error("off tick count wrong");
   property p_fd_ticks;
      $stable(fast_decay_o) |-> fast_decay_ticks_o == 10'(({6'h00, fast_decay_o} + 10'h001) * 10'h008 - 10'h001);
   endproperty
   a_fd_ticks: assert property (p_fd_ticks) else $error("fast decay tick count wrong");
   property p_ext_en;
      $stable(period_word_o) |-> ext_enable_mode_o == (period_word_o[12:0] == 13'h0000);
   endproperty
   a_ext_en: assert property (p_ext_en) else $error("external enable mode wrong");
   property p_done_pulse;
      frame_done_o |=> !frame_done_o;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("frame done longer than a cycle");
   // Words may move only beside a completed frame while awake.
   property p_store;
      (sleep_n_i && $past(sleep_n_i, 4) && !$stable({chop_word_o, common_word_o, period_word_o, on_word_o}))
         |-> (##[0:1] frame_done_o) or $past(frame_done_o);
   endproperty
   a_store: assert property (p_store) else $error("word changed without a frame");
   property p_sleep;
      s_asleep |-> chop_word_o == 14'h0040 && common_word_o == 14'h0000 && period_word_o == 14'h0000
         && on_word_o == 14'h0000 && !bridge_active_o && motor_off_o;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep did not reset the port");
   property p_awake;
      s_awake |-> bridge_active_o;
   endproperty
   a_awake: assert property (p_awake) else $error("bridge not active while awake");
   property p_quiet;
      s_asleep |-> !frame_done_o;
   endproperty
   a_quiet: assert property (p_quiet) else $error("frame accepted while asleep");
endmodule : mscp_port_monitor

bind mscp_port mscp_port_monitor #(.WAKE_CYCLES(WAKE_CYCLES), .TICKS_PER_S(TICKS_PER_S)) i_mscp_port_monitor (
   .ref_clk_i, .reset_n_i, .sleep_n_i, .chop_word_o, .common_word_o, .period_word_o, .on_word_o,
   .blank_sel_o, .off_time_o, .fast_decay_o, .zero_current_mode_o, .sync_rect_en_o, .int_decay_slow_o,
   .ext_decay_slow_o, .dac_code_o, .current_limit_en_o, .ext_enable_mode_o, .off_ticks_o,
   .fast_decay_ticks_o, .bridge_active_o, .motor_off_o, .frame_done_o);

// ===== tb/mscp_host_model.sv
// Host model that shifts frames into the serial configuration port.
`timescale 1ns/1ps
module mscp_host_model (
   // Serial link
   output logic ser_clk_o,
   output logic ser_data_o,
   output logic load_strobe_o
);
   initial
   begin
      ser_clk_o     = 1'b0;
      ser_data_o    = 1'b0;
      load_strobe_o = 1'b1;
   end
   // Data turns over between edges, so a port sampling the wrong edge picks up the inverse.
   task automatic shift(input logic [20:0] f, input int n, input bit fall);
      load_strobe_o = 1'b0;
      #50;
      for (int i = n - 1; i >= 0; i--)
      begin
         if (fall)
         begin
            ser_clk_o = 1'b1;
            #8 ser_data_o = f[i];
            #8 ser_clk_o = 1'b0;
            #8 ser_data_o = ~f[i];
            #8;
         end
         else
         begin
            ser_data_o = f[i];
            #8 ser_clk_o = 1'b1;
            #8 ser_data_o = ~f[i];
            #8 ser_clk_o = 1'b0;
            #8;
         end
      end
      #50;
      load_strobe_o = 1'b1;
   endtask : shift
   task automatic send_long(input logic [20:0] f);
      if (f[17:14] != 4'h3)
         shift(f, 21, f[18]);
   endtask : send_long
   task automatic send_short(input logic [15:0] f);
      shift({5'h00, f}, 16, 1'b0);
   endtask : send_short
endmodule : mscp_host_model

// ===== tb/test_motor_serial_config_port.sv
// Self-checking bench for the motor serial configuration port.
`timescale 1ns/1ps
module test_motor_serial_config_port;
   logic        ref_clk_i, reset_n_i, sleep_n_i, short_format_i;
   logic [2:0]  pins;
   wire         ser_clk, ser_data, load_strobe;
   wire  [13:0] chop, common, period, on_w;
   wire  [9:0]  off_tk, fd_tk;
   wire  [4:0]  off_t;
   wire  [3:0]  fd, dac;
   wire  [1:0]  blank;
   wire         zc, sr, ids, eds, dir, cle, exm, act, moff, done;
   int          errors, n_checks;

   mscp_host_model i_mscp_host_model (.ser_clk_o(ser_clk), .ser_data_o(ser_data), .load_strobe_o(load_strobe));
   mscp_port #(.TICKS_PER_S(10)) i_mscp_port (
      .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .ser_clk_i(ser_clk), .ser_data_i(ser_data),
      .load_strobe_i(load_strobe), .device_select_pin_0_i(pins[0]), .device_select_pin_1_i(pins[1]),
      .device_select_pin_2_i(pins[2]), .short_format_i(short_format_i), .sleep_n_i(sleep_n_i),
      .chop_word_o(chop), .common_word_o(common), .period_word_o(period), .on_word_o(on_w),
      .blank_sel_o(blank), .off_time_o(off_t), .fast_decay_o(fd), .zero_current_mode_o(zc),
      .sync_rect_en_o(sr), .int_decay_slow_o(ids), .ext_decay_slow_o(eds), .direction_o(dir),
      .dac_code_o(dac), .current_limit_en_o(cle), .ext_enable_mode_o(exm), .off_ticks_o(off_tk),
      .fast_decay_ticks_o(fd_tk), .bridge_active_o(act), .motor_off_o(moff), .frame_done_o(done));

   initial
   begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [13:0] seen, input logic [13:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic give_verdict();
      $display("Checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask : cyc
   task automatic settle(input bit wd);
      int k;
      k = 0;
      while (wd && done !== 1'b1 && k < 20)
      begin
         @(negedge ref_clk_i);
         k++;
      end
      if (wd && done !== 1'b1)
      begin
         errors++;
         $display("Error frame_done expected 1 seen 0");
         give_verdict();
      end
      cyc(10);
   endtask : settle
   task automatic lf(input logic [2:0] id, input logic [3:0] sel, input logic [13:0] d, input bit wd);
      i_mscp_host_model.send_long({id, sel, d});
      settle(wd);
   endtask : lf
   task automatic sf(input logic [1:0] sel, input logic [13:0] d);
      i_mscp_host_model.send_short({sel, d});
      settle(1'b1);
   endtask : sf
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      check("chop", chop, 14'h0040);
      check("common", common | period | on_w, 14'h0000);
      check("off_time", 14'(off_t), 14'h0010);
      check("off_ticks", 14'(off_tk), 14'h0087);
      check("fd_ticks", 14'(fd_tk), 14'h0007);
      check("mode_bits", 14'({exm, cle, act}), 14'h0005);
      $display("Test reset values done");
   endtask : t_reset
   task automatic t_long();
      lf(3'h3, 4'h0, 14'h1FFD, 1'b1);
      check("chop", chop, 14'h1FFD);
      check("off_ticks", 14'(off_tk), 14'h00FF);
      check("fd_ticks", 14'(fd_tk), 14'h007F);
      check("fast_decay", 14'(fd), 14'h000F);
      check("chop_bits", 14'({sr, zc, blank}), 14'h000D);
      lf(3'h0, 4'h2, 14'h2700, 1'b1);
      check("common", common, 14'h2700);
      check("common_bits", 14'({cle, dac, dir, eds, ids}), 14'h00CE);
      lf(3'h3, 4'h4, 14'h1FFF, 1'b1);
      check("period", period, 14'h1FFF);
      check("ext_mode", 14'(exm), 14'h0000);
      lf(3'h3, 4'h6, 14'h0123, 1'b1);
      check("on", on_w, 14'h0123);
      check("direction", 14'(dir), 14'h0000);
      pins = 3'h2;
      cyc(4);
      lf(3'h2, 4'h2, 14'h2700, 1'b1);
      check("direction", 14'(dir), 14'h0001);
      $display("Test long frames done");
   endtask : t_long
   task automatic t_ignored();
      logic [3:0] sels [3] = '{4'h1, 4'h5, 4'h7};
      lf(3'h5, 4'h0, 14'h0000, 1'b0);
      check("chop", chop, 14'h1FFD);
      foreach (sels[i])
      begin
         lf(3'h2, sels[i], 14'h2AAA, 1'b1);
         check("chop", chop, 14'h1FFD);
         check("period", period, 14'h1FFF);
         check("on", on_w, 14'h0123);
      end
      $display("Test ignored words done");
   endtask : t_ignored
   task automatic t_short();
      short_format_i = 1'b1;
      cyc(4);
      sf(2'h0, 14'h0004);
      check("chop", chop, 14'h0004);
      check("off_ticks", 14'(off_tk), 14'h000F);
      sf(2'h1, 14'h1FFD);
      check("chop", chop, 14'h0004);
      sf(2'h2, 14'h0400);
      check("dac", 14'({cle, dac}), 14'h0011);
      short_format_i = 1'b0;
      cyc(4);
      $display("Test short frames done");
   endtask : t_short
   task automatic t_wdog();
      lf(3'h2, 4'hF, 14'h0001, 1'b1);
      cyc(400);
      check("motor_off", 14'(moff), 14'h0000);
      lf(3'h2, 4'hF, 14'h0001, 1'b1);
      cyc(400);
      check("motor_off", 14'(moff), 14'h0000);
      cyc(300);
      check("motor_off", 14'(moff), 14'h0001);
      $display("Test watchdog done");
   endtask : t_wdog
   task automatic t_sleep();
      sleep_n_i = 1'b0;
      cyc(6);
      check("chop", chop, 14'h0040);
      check("words", common | period | on_w, 14'h0000);
      check("act_off", 14'({act, moff}), 14'h0001);
      sleep_n_i = 1'b1;
      cyc(20);
      lf(3'h2, 4'h0, 14'h1FFD, 1'b0);
      check("chop", chop, 14'h0040);
      cyc(260);
      lf(3'h2, 4'h0, 14'h1FFD, 1'b1);
      check("chop", chop, 14'h1FFD);
      $display("Test sleep and wake done");
   endtask : t_sleep
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      errors         = 0;
      n_checks       = 0;
      reset_n_i      = 1'b0;
      sleep_n_i      = 1'b1;
      short_format_i = 1'b0;
      pins           = 3'h3;
      cyc(12);
      reset_n_i = 1'b1;
      cyc(270);
      t_reset();
      t_long();
      t_ignored();
      t_short();
      t_wdog();
      t_sleep();
      give_verdict();
   end
endmodule : test_motor_serial_config_port
